/* common/ami_pkg.sv */
// Functional notes
// - Line pulses driven only while transmit clock is low, polarity from data input.
// - Line pulse lasts the clock low phase; width set by clock, not timers.
// - Both data inputs high in one bit inhibits the driver entirely.
// - Receiver gives separate unipolar outputs for positive and negative pulses.
// - Received data latched by recovered clock, which is also output.
// - Recovered clock 488 ns period, 244 ns high; data lasts one bit. Code gives 24-cycle halves: 240 ns high, 480 ns free running.
// - Loss-of-signal asserts 0.7 to 1.3 peak time constants after input removal.
// - Line loopback low sends recovered data and clock into transmitter, outputs kept.
// - Local loopback low sends transmit inputs to receiver outputs, line still driven.
// - HDB3 data passes unchanged both ways; no substitution coding here.
package ami_pkg;

   localparam int unsigned SYS_CLK_PERIOD_NS = 10;
   localparam int unsigned BIT_PERIOD_NS     = 488;
   localparam int unsigned HALF_BIT_NS       = 244;
   localparam int unsigned RX_STAB_MS        = 5;
   // Nominal peak-detector time constant for the usual external network
   localparam int unsigned LOS_DELAY_NS      = 415000;

   localparam int unsigned RX_CNT_W          = 8;
   // Longest half period, rounded down to whole cycles
   localparam logic [RX_CNT_W-1:0] RX_HALF_CYC =
      RX_CNT_W'(HALF_BIT_NS / SYS_CLK_PERIOD_NS);
   localparam logic [RX_CNT_W-1:0] RX_CNT_RST = 8'h00;

   typedef struct packed {
      logic plus;
      logic minus;
   } ami_pair_t;

   localparam ami_pair_t PAIR_RST = 2'h0;

   // Asynchronous pin inputs, synchronised as one group
   typedef struct packed {
      logic      tx_clk;
      ami_pair_t tx;
      logic      line_lb_n;
      logic      local_lb_n;
      ami_pair_t rx;
   } ami_pins_t;

   // Loopback controls idle high, clock idle high
   localparam ami_pins_t PINS_RST = 7'h4c;

endpackage

/* rtl/ami_line_if.sv */
`timescale 1ns/1ps
`default_nettype none
module ami_line_if #(
   parameter int unsigned LOS_DELAY_CYC = ami_pkg::LOS_DELAY_NS / ami_pkg::SYS_CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic clk_en,
   // Transmit side from framer
   input  wire logic tx_clock,
   input  wire logic tx_plus_data,
   input  wire logic tx_minus_data,
   // Loopback controls, active low
   input  wire logic line_loopback_n,
   input  wire logic local_loopback_n,
   // Detected line pulses from receive comparators
   input  wire logic rx_line_plus,
   input  wire logic rx_line_minus,
   // Line driver commands
   output logic      line_drive_plus,
   output logic      line_drive_minus,
   // Receive side to framer
   output logic      rx_plus_data,
   output logic      rx_minus_data,
   output logic      recovered_clock,
   output logic      signal_lost_flag
);

   localparam int unsigned LOS_W = $clog2(LOS_DELAY_CYC + 1);
   localparam logic [LOS_W-1:0] LOS_LIMIT = LOS_W'(LOS_DELAY_CYC);
   localparam logic [LOS_W-1:0] LOS_RST   = '0;

   // Pin synchronisers
   ami_pkg::ami_pins_t pins_in;
   ami_pkg::ami_pins_t meta_q, meta_d;
   ami_pkg::ami_pins_t pin_q, pin_d;
   ami_pkg::ami_pins_t pin_old_q, pin_old_d;

   always_comb begin
      pins_in.tx_clk     = tx_clock;
      pins_in.tx.plus    = tx_plus_data;
      pins_in.tx.minus   = tx_minus_data;
      pins_in.line_lb_n  = line_loopback_n;
      pins_in.local_lb_n = local_loopback_n;
      pins_in.rx.plus    = rx_line_plus;
      pins_in.rx.minus   = rx_line_minus;
      meta_d    = clk_en ? pins_in : meta_q;
      pin_d     = clk_en ? meta_q : pin_q;
      pin_old_d = clk_en ? pin_q : pin_old_q;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_q    <= ami_pkg::PINS_RST;
         pin_q     <= ami_pkg::PINS_RST;
         pin_old_q <= ami_pkg::PINS_RST;
      end else begin
         meta_q    <= meta_d;
         pin_q     <= pin_d;
         pin_old_q <= pin_old_d;
      end
   end

   logic rx_evt_plus;
   logic rx_evt_minus;
   logic rx_evt;
   assign rx_evt_plus  = pin_q.rx.plus & ~pin_old_q.rx.plus;
   assign rx_evt_minus = pin_q.rx.minus & ~pin_old_q.rx.minus;
   assign rx_evt       = rx_evt_plus | rx_evt_minus;

   // Clock recovery: half-period counter realigned on each pulse.
   // A pulse restarts the low phase so the next rise lands mid-bit.
   logic [ami_pkg::RX_CNT_W-1:0] ph_q, ph_d;
   logic                         rclk_q, rclk_d;
   ami_pkg::ami_pair_t           pend_q, pend_d;
   ami_pkg::ami_pair_t           rdat_q, rdat_d;
   logic                         latch_evt;

   always_comb begin
      ph_d      = ph_q;
      rclk_d    = rclk_q;
      pend_d    = pend_q;
      rdat_d    = rdat_q;
      latch_evt = 1'b0;
      if (clk_en) begin
         if (rx_evt) begin
            ph_d   = ami_pkg::RX_CNT_RST;
            rclk_d = 1'b0;
         end else if (ph_q == ami_pkg::RX_HALF_CYC - 8'h01) begin
            ph_d   = ami_pkg::RX_CNT_RST;
            rclk_d = ~rclk_q;
            latch_evt = ~rclk_q;
         end else begin
            ph_d = ph_q + 8'h01;
         end
         if (latch_evt) begin
            rdat_d = pend_q;
            pend_d = ami_pkg::PAIR_RST;
         end
         // A pulse in the latch cycle is kept for the next bit
         if (rx_evt_plus) begin
            pend_d.plus = 1'b1;
         end
         if (rx_evt_minus) begin
            pend_d.minus = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ph_q   <= ami_pkg::RX_CNT_RST;
         rclk_q <= 1'b0;
         pend_q <= ami_pkg::PAIR_RST;
         rdat_q <= ami_pkg::PAIR_RST;
      end else begin
         ph_q   <= ph_d;
         rclk_q <= rclk_d;
         pend_q <= pend_d;
         rdat_q <= rdat_d;
      end
   end

   // Loss of signal: quiet-time counter, saturating
   logic [LOS_W-1:0] quiet_q, quiet_d;
   logic             los_q, los_d;

   always_comb begin
      quiet_d = quiet_q;
      los_d   = los_q;
      if (clk_en) begin
         if (rx_evt) begin
            quiet_d = LOS_RST;
         end else if (quiet_q != LOS_LIMIT) begin
            quiet_d = quiet_q + LOS_W'(1);
         end
         los_d = (quiet_d == LOS_LIMIT);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         quiet_q <= LOS_RST;
         los_q   <= 1'b0;
      end else begin
         quiet_q <= quiet_d;
         los_q   <= los_d;
      end
   end

   // Loopback muxes; each control acts on its own path only
   logic               src_clk;
   ami_pkg::ami_pair_t src_dat;
   assign src_clk = pin_q.line_lb_n ? pin_q.tx_clk : rclk_q;
   assign src_dat = pin_q.line_lb_n ? pin_q.tx : rdat_q;

   // Transmitter: data captured at the clock fall, driven during low phase.
   // Synchroniser delay shifts both edges alike, so width is preserved.
   logic               src_clk_old_q, src_clk_old_d;
   ami_pkg::ami_pair_t cap_q, cap_d;
   ami_pkg::ami_pair_t drv_q, drv_d;
   logic               src_fall;
   ami_pkg::ami_pair_t bit_now;
   assign src_fall = src_clk_old_q & ~src_clk;
   // New bit drives from the fall cycle itself, so no cycle of width is lost
   assign bit_now  = src_fall ? src_dat : cap_q;

   always_comb begin
      src_clk_old_d = src_clk_old_q;
      cap_d         = cap_q;
      drv_d         = drv_q;
      if (clk_en) begin
         src_clk_old_d = src_clk;
         if (src_fall) begin
            cap_d = src_dat;
         end
         drv_d.plus  = ~src_clk & bit_now.plus & ~bit_now.minus;
         drv_d.minus = ~src_clk & bit_now.minus & ~bit_now.plus;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         src_clk_old_q <= 1'b1;
         cap_q         <= ami_pkg::PAIR_RST;
         drv_q         <= ami_pkg::PAIR_RST;
      end else begin
         src_clk_old_q <= src_clk_old_d;
         cap_q         <= cap_d;
         drv_q         <= drv_d;
      end
   end

   // Receive outputs, with local loopback substituting the transmit inputs
   ami_pkg::ami_pair_t rxo_q, rxo_d;
   logic               recovered_clock_o_q, recovered_clock_o_d;

   always_comb begin
      rxo_d     = rxo_q;
      recovered_clock_o_d = recovered_clock_o_q;
      if (clk_en) begin
         rxo_d     = pin_q.local_lb_n ? rdat_q : pin_q.tx;
         recovered_clock_o_d = pin_q.local_lb_n ? rclk_q : pin_q.tx_clk;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rxo_q     <= ami_pkg::PAIR_RST;
         recovered_clock_o_q <= 1'b0;
      end else begin
         rxo_q     <= rxo_d;
         recovered_clock_o_q <= recovered_clock_o_d;
      end
   end

   assign line_drive_plus  = drv_q.plus;
   assign line_drive_minus = drv_q.minus;
   assign rx_plus_data     = rxo_q.plus;
   assign rx_minus_data    = rxo_q.minus;
   assign recovered_clock  = recovered_clock_o_q;
   assign signal_lost_flag = los_q;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst || !clk_en);

   a_drive_clk_low: assert property (
      (line_drive_plus || line_drive_minus) |-> !$past(src_clk))
      else $error("line pulse outside transmit clock low phase");

   a_pulse_start: assert property (
      $rose(line_drive_plus) |-> $past(src_fall))
      else $error("positive pulse did not start at clock fall");

   a_pulse_end: assert property (
      $fell(line_drive_plus) |-> $past(src_clk) || $past(src_fall))
      else $error("positive pulse ended before clock rise");

   a_both_inhibit: assert property (
      (bit_now.plus && bit_now.minus) |=> !line_drive_plus && !line_drive_minus)
      else $error("driver not inhibited on dual data");

   a_rx_separate: assert property (
      (pin_q.local_lb_n && latch_evt && pend_q.plus) |-> ##2 rx_plus_data)
      else $error("detected positive pulse not presented");

   a_rx_hold_bit: assert property (
      ($changed(rdat_q)) |-> $past(latch_evt))
      else $error("receive data changed away from clock rise");

   a_rclk_half: assert property (
      ph_q < ami_pkg::RX_HALF_CYC)
      else $error("recovered clock half period overrun");

   a_los_delay: assert property (
      $rose(signal_lost_flag) |-> $past(quiet_q) >= LOS_LIMIT - LOS_W'(1))
      else $error("loss of signal raised too early");

   a_los_clear: assert property (
      rx_evt |=> ##1 !signal_lost_flag)
      else $error("loss of signal not cleared by pulse");

   a_line_loop: assert property (
      (!pin_q.line_lb_n && src_fall) |=> cap_q == $past(rdat_q))
      else $error("line loopback did not feed recovered data");

   a_local_loop: assert property (
      !pin_q.local_lb_n |=> recovered_clock == $past(pin_q.tx_clk))
      else $error("local loopback did not route transmit clock");

   a_minus_start: assert property (
      $rose(line_drive_minus) |-> $past(src_fall))
      else $error("negative pulse did not start at clock fall");

   a_minus_end: assert property (
      $fell(line_drive_minus) |-> $past(src_clk) || $past(src_fall))
      else $error("negative pulse ended before clock rise");

   a_drive_excl: assert property (
      !(line_drive_plus && line_drive_minus))
      else $error("both line pulse commands active together");

   a_rx_minus: assert property (
      (pin_q.local_lb_n && latch_evt && pend_q.minus) |-> ##2 rx_minus_data)
      else $error("detected negative pulse not presented");

   a_rclk_out: assert property (
      pin_q.local_lb_n |=> recovered_clock == $past(rclk_q))
      else $error("recovered clock not presented on output");

   a_los_early: assert property (
      (quiet_q < LOS_LIMIT - LOS_W'(1)) |=> !signal_lost_flag)
      else $error("loss of signal raised before quiet limit");

   a_tx_pass: assert property (
      (pin_q.line_lb_n && src_fall) |=> cap_q == $past(pin_q.tx))
      else $error("transmit data altered on its way to the driver");

   c_pos_pulse:  cover property ($rose(line_drive_plus));
   c_dual_bit:   cover property (cap_q.plus && cap_q.minus && !src_clk);
   c_los_raised: cover property ($rose(signal_lost_flag));
   c_both_loops: cover property (!pin_q.line_lb_n && !pin_q.local_lb_n && latch_evt);

endmodule
`default_nettype wire

/* verif/ami_framer_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ami_framer_model #(
   parameter real HALF_NS = 244.0
) (
   // Bit to send in the next period
   input  wire logic nxt_plus,
   input  wire logic nxt_minus,
   // Transmit pins
   output logic      tx_clock,
   output logic      tx_plus_data,
   output logic      tx_minus_data
);
   // Free running clock, 488 ns with 244 ns low by default
   initial begin
      tx_clock = 1'b1;
      forever #(HALF_NS) tx_clock = ~tx_clock;
   end
   // Load at the rise so data is stable through the low phase
   initial begin
      tx_plus_data  = 1'b0;
      tx_minus_data = 1'b0;
      forever begin
         @(posedge tx_clock);
         tx_plus_data  = nxt_plus;
         tx_minus_data = nxt_minus;
      end
   end
endmodule
`default_nettype wire

/* verif/test_ami_pcm_line_interface_logic.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ami_pcm_line_interface_logic;
   localparam int unsigned LOS_CYC = 200;
   // Fast 125 ns link clock keeps the run short
   localparam real         TX_HALF_NS = 62.5;
   logic        sys_clk, rst, clk_en, line_loopback_n, local_loopback_n;
   logic        rx_line_plus, rx_line_minus, nxt_plus, nxt_minus;
   wire logic   tx_clock, tx_plus_data, tx_minus_data, line_drive_plus, line_drive_minus;
   wire logic   rx_plus_data, rx_minus_data, recovered_clock, signal_lost_flag;
   wire logic [5:0] obs = {line_drive_plus, line_drive_minus, rx_plus_data,
                           rx_minus_data, recovered_clock, signal_lost_flag};
   logic [15:0] cnt [6];
   int          n_fail = 0;
   int          n_tests = 0;

   ami_line_if #(.LOS_DELAY_CYC(LOS_CYC)) ami_line_if_i (
      .sys_clk, .rst, .clk_en, .tx_clock, .tx_plus_data, .tx_minus_data,
      .line_loopback_n, .local_loopback_n, .rx_line_plus, .rx_line_minus,
      .line_drive_plus, .line_drive_minus, .rx_plus_data, .rx_minus_data,
      .recovered_clock, .signal_lost_flag);
   ami_framer_model #(.HALF_NS(TX_HALF_NS)) ami_framer_model_i (
      .nxt_plus, .nxt_minus, .tx_clock, .tx_plus_data, .tx_minus_data);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic tx_bits();
      logic [1:0] codes [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
      foreach (codes[k]) begin
         {nxt_plus, nxt_minus} = codes[k];
         @(posedge tx_clock);
         @(negedge tx_clock);
         foreach (cnt[i]) cnt[i] = '0;
         // Window shorter than one link period holds at most one pulse
         repeat (12) begin
            @(negedge sys_clk);
            foreach (cnt[i]) cnt[i] += 16'(obs[i]);
         end
         check("drive plus", 16'(codes[k] == 2'b10 ? cnt[5] inside {[6:7]} : cnt[5] == 0), 16'h1);
         check("drive minus", 16'(codes[k] == 2'b01 ? cnt[4] inside {[6:7]} : cnt[4] == 0), 16'h1);
      end
      {nxt_plus, nxt_minus} = 2'b00;
   endtask

   // One 48 cycle bit on the receive line, counting every output
   task automatic rx_one(input logic p, input logic m, input logic chk);
      foreach (cnt[i]) cnt[i] = '0;
      for (int c = 0; c < 48; c++) begin
         @(negedge sys_clk);
         rx_line_plus  = p & (c < 8);
         rx_line_minus = m & (c < 8);
         foreach (cnt[i]) cnt[i] += 16'(obs[i]);
         if (chk && c == 10) check("rclk low", 16'(recovered_clock), 16'h0);
         if (chk && c == 30) check("rx pair", 16'({rx_plus_data, rx_minus_data, recovered_clock}), 16'({p, m, 1'b1}));
      end
   endtask

   task automatic rx_bits();
      // Receiver still settling, not judged
      rx_one(1'b1, 1'b0, 1'b0);
      rx_one(1'b1, 1'b0, 1'b1);
      check("rclk high width", cnt[1], 16'(ami_pkg::RX_HALF_CYC));
      rx_one(1'b1, 1'b0, 1'b1);
      check("rx plus width", cnt[3], 16'd48);
      rx_one(1'b0, 1'b1, 1'b1);
      rx_one(1'b0, 1'b0, 1'b1);
      rx_one(1'b0, 1'b1, 1'b1);
   endtask

   task automatic los_test();
      int n = 48;
      check("los idle", 16'(signal_lost_flag), 16'h0);
      while (signal_lost_flag !== 1'b1 && n < 1000) begin
         @(negedge sys_clk);
         n++;
      end
      check("los delay", 16'(n >= LOS_CYC * 7 / 10 && n <= LOS_CYC * 13 / 10), 16'h1);
      rx_one(1'b1, 1'b0, 1'b0);
      check("los cleared", 16'(signal_lost_flag), 16'h0);
   endtask

   // Line sends plus marks, framer sends minus marks
   task automatic loop_test(input logic ln, input logic lc);
      logic [15:0] tot [6];
      line_loopback_n  = ln;
      local_loopback_n = lc;
      {nxt_plus, nxt_minus} = 2'b01;
      rx_one(1'b1, 1'b0, 1'b0);
      foreach (tot[i]) tot[i] = '0;
      repeat (4) begin
         rx_one(1'b1, 1'b0, 1'b0);
         foreach (tot[i]) tot[i] += cnt[i];
      end
      check("loop rx plus", 16'(lc ? tot[3] > 150 : tot[3] == 0), 16'h1);
      check("loop rx minus", 16'(lc ? tot[2] == 0 : tot[2] > 150), 16'h1);
      check("loop drive plus", 16'(ln ? tot[5] == 0 : tot[5] > 40), 16'h1);
      check("loop drive minus", 16'(ln ? tot[4] > 40 : tot[4] == 0), 16'h1);
      check("loop rclk", 16'(tot[1] inside {[80:112]}), 16'h1);
      line_loopback_n  = 1'b1;
      local_loopback_n = 1'b1;
      {nxt_plus, nxt_minus} = 2'b00;
   endtask

   // Clock enable low must hold every output still, line edges ignored
   task automatic freeze_test();
      logic [5:0] held;
      held   = obs;
      clk_en = 1'b0;
      repeat (50) begin
         @(negedge sys_clk);
         rx_line_plus = ~rx_line_plus;
         check("frozen outputs", 16'(obs), 16'(held));
      end
      clk_en = 1'b1;
   endtask

   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      line_loopback_n = 1'b1;
      local_loopback_n = 1'b1;
      rx_line_plus = 1'b0;
      rx_line_minus = 1'b0;
      {nxt_plus, nxt_minus} = 2'b00;
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      tx_bits();
      rx_bits();
      los_test();
      loop_test(1'b1, 1'b0);
      loop_test(1'b0, 1'b1);
      loop_test(1'b0, 1'b0);
      freeze_test();
      stop_test();
   end

   // Whole run needs about 1380 cycles
   initial begin
      #200000;
      n_fail++;
      stop_test();
   end
endmodule
`default_nettype wire
